// >>> hw/tmbs_pkg.sv
/*
 * Shared constants, types and helpers of the temperature monitor bus slave.
 * Assumes a 50 MHz system clock; all times below turn into cycle counts here.
 */
package tmbs_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int TIMEOUT_MS = 30;
    localparam int TIMEOUT_CYCLES = CLK_HZ / 1000 * TIMEOUT_MS;
    localparam int CONV_TIME_US = 100;
    localparam int CONV_CYCLES = CLK_HZ / 1_000_000 * CONV_TIME_US;

    // ------------------------------------------------------------
    // register pointers and fields
    // ------------------------------------------------------------
    localparam logic [7:0] PTR_LOCAL_HI = 8'h00;
    localparam logic [7:0] PTR_REMOTE_HI = 8'h01;
    localparam logic [7:0] PTR_CONFIG1 = 8'h09;
    localparam logic [7:0] PTR_LOCAL_LO = 8'h10;
    localparam logic [7:0] PTR_REMOTE_LO = 8'h11;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] CONFIG1_RESET = 8'h00;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_VALUE = 8'h00;
    localparam int PD_BIT = 6;
    localparam int OPEN_BIT = 0;
    localparam int SUPPLY_INVALID_FLAG_BIT = 1;
    localparam logic [7:0] SHORT_TEMP = 8'hc0;
    localparam logic [4:0] HS_CODE = 5'h01;
    // synchroniser order: scl, sda, supply valid, comparator trip, short
    localparam logic [4:0] SYNC_RESET = 5'h18;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
    } tmbs_result_t;

    typedef struct packed {
        logic [7:0] whole;
        logic [3:0] frac;
    } tmbs_sample_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR_BYTE, ST_WR_ACK, ST_RD_BYTE, ST_RD_ACK, ST_IGNORE
    } tmbs_bus_state_t;

    // low result byte: fraction in the top nibble, flags in the bottom bits
    function automatic logic [7:0] tmbs_low_byte(input logic [3:0] frac, input logic supply_invalid_flag, input logic open_flag);
        tmbs_low_byte = {frac, 2'b00, supply_invalid_flag, open_flag};
    endfunction

endpackage

// >>> hw/tmbs_slave.sv
/*
 * Temperature monitor two-wire slave with conversion sequencing and result flags.
 * Assumes an external master drives SCL and a pull-up on SDA; analog results
 * arrive on clk, comparator levels arrive asynchronously.
 */
`timescale 1ns/1ns
module tmbs_slave
    import tmbs_pkg::*;
#(
    parameter int TIMEOUT_CYC = TIMEOUT_CYCLES,
    parameter int CONV_CYC = CONV_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic [6:0] slave_addr,
    input wire logic supply_valid,
    input wire logic remote_comparator_trip,
    input wire logic remote_short,
    input wire tmbs_sample_t local_sample,
    input wire tmbs_sample_t remote_sample,
    output logic power_down_select,
    output logic converting,
    output logic hs_mode,
    output tmbs_result_t local_result,
    output tmbs_result_t remote_result
);

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    if (TIMEOUT_CYC < 2) begin : g_bad_timeout
        $error("timeout count too small");
    end
    if (CONV_CYC < 2) begin : g_bad_conv
        $error("conversion count too small");
    end

    localparam int TW = $clog2(TIMEOUT_CYC + 1);
    localparam int CW = $clog2(CONV_CYC + 1);
    localparam logic [TW-1:0] TMO_LAST = TW'(TIMEOUT_CYC);
    localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYC - 1);

    // ------------------------------------------------------------
    // input synchronisation and bus conditions
    // ------------------------------------------------------------
    logic [4:0] synced;
    logic scl;
    logic sda;
    logic supply_ok;
    logic trip;
    logic shorted;
    logic scl_prev;
    logic sda_prev;

    tmbs_sync #(.WIDTH(5), .RESET_VALUE(SYNC_RESET)) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .async_in({scl_in, sda_in, supply_valid, remote_comparator_trip, remote_short}),
        .sync_out(synced)
    );

    assign {scl, sda, supply_ok, trip, shorted} = synced;

    wire scl_rise = scl & ~scl_prev;
    wire scl_fall = ~scl & scl_prev;
    wire start_seen = scl & scl_prev & sda_prev & ~sda;
    wire stop_seen = scl & scl_prev & ~sda_prev & sda;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_prev <= scl;
            sda_prev <= sda;
        end
    end

    // ------------------------------------------------------------
    // serial state machine
    // ------------------------------------------------------------
    tmbs_bus_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] tx;
    logic rw;
    logic first_wr;
    logic busy;
    logic [7:0] pointer;
    logic [7:0] config1;
    logic [TW-1:0] tmo_cnt;

    // the byte is complete on the falling edge after the eighth rising edge
    wire byte_done = scl_fall && (bit_cnt == 4'h8);
    wire addr_match = (shift[7:1] == slave_addr);
    wire hs_code = (shift[7:3] == HS_CODE);
    wire tmo_hit = busy && (tmo_cnt == TMO_LAST);
    wire ptr_load = byte_done && (state == ST_WR_BYTE) && first_wr;
    wire cfg_write = byte_done && (state == ST_WR_BYTE) && !first_wr && (pointer == PTR_CONFIG1);
    wire [7:0] rd_data;

    assign rd_data = (pointer == PTR_LOCAL_HI) ? local_result.hi :
                     (pointer == PTR_REMOTE_HI) ? remote_result.hi :
                     (pointer == PTR_LOCAL_LO) ? local_result.lo :
                     (pointer == PTR_REMOTE_LO) ? remote_result.lo :
                     (pointer == PTR_CONFIG1) ? config1 : UNMAPPED_VALUE;

    // timeout counts any low line while a transfer is open; a master holding
    // either line low for 30 ms would trip it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tmo_cnt <= '0;
        end else if (!busy || (scl && sda) || tmo_hit) begin
            tmo_cnt <= '0;
        end else begin
            tmo_cnt <= tmo_cnt + 1'b1;
        end
    end

    // sda_out never changes: the pin is open drain and only pulled low.
    // scl has no output at all, so the block can never clock the bus.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            bit_cnt <= '0;
            shift <= '0;
            tx <= '0;
            rw <= 1'b0;
            first_wr <= 1'b0;
            busy <= 1'b0;
            hs_mode <= 1'b0;
            sda_oe_n <= 1'b1;
        end else if (tmo_hit) begin
            state <= ST_IGNORE;
            sda_oe_n <= 1'b1;
            busy <= 1'b0;
            hs_mode <= 1'b0;
        end else if (start_seen) begin
            state <= ST_ADDR;
            bit_cnt <= '0;
            sda_oe_n <= 1'b1;
            busy <= 1'b1;
        end else if (stop_seen) begin
            state <= ST_IDLE;
            sda_oe_n <= 1'b1;
            busy <= 1'b0;
            hs_mode <= 1'b0;
        end else begin
            if (scl_rise) begin
                shift <= {shift[6:0], sda};
                bit_cnt <= bit_cnt + 1'b1;
            end
            unique case (state)
                ST_IDLE, ST_IGNORE: begin
                    sda_oe_n <= 1'b1;
                end
                ST_ADDR: begin
                    if (byte_done) begin
                        if (hs_code) begin
                            hs_mode <= 1'b1;
                            state <= ST_IGNORE;
                        end else if (addr_match) begin
                            rw <= shift[0];
                            sda_oe_n <= 1'b0;
                            state <= ST_ADDR_ACK;
                        end else begin
                            state <= ST_IGNORE;
                        end
                    end
                end
                ST_ADDR_ACK, ST_WR_ACK: begin
                    // released only on the falling edge: low through SCL high.
                    if (scl_fall) begin
                        bit_cnt <= '0;
                        if (rw && state == ST_ADDR_ACK) begin
                            tx <= rd_data;
                            sda_oe_n <= rd_data[7];
                            state <= ST_RD_BYTE;
                        end else begin
                            first_wr <= (state == ST_ADDR_ACK);
                            sda_oe_n <= 1'b1;
                            state <= ST_WR_BYTE;
                        end
                    end
                end
                ST_WR_BYTE: begin
                    if (byte_done) begin
                        first_wr <= 1'b0;
                        sda_oe_n <= 1'b0;
                        state <= ST_WR_ACK;
                    end
                end
                ST_RD_BYTE: begin
                    // drive changes only on SCL falling edges.
                    if (byte_done) begin
                        sda_oe_n <= 1'b1;
                        state <= ST_RD_ACK;
                    end else if (scl_fall) begin
                        tx <= {tx[6:0], 1'b0};
                        sda_oe_n <= tx[6];
                    end
                end
                ST_RD_ACK: begin
                    if (scl_rise && sda) begin
                        state <= ST_IGNORE;
                    end else if (scl_fall) begin
                        // further bytes for as long as the master acknowledges.
                        bit_cnt <= '0;
                        tx <= rd_data;
                        sda_oe_n <= rd_data[7];
                        state <= ST_RD_BYTE;
                    end
                end
            endcase
        end
    end

    // pointer only moves on the first byte of a write.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pointer <= PTR_RESET;
            config1 <= CONFIG1_RESET;
        end else begin
            if (ptr_load) begin
                pointer <= shift;
            end
            if (cfg_write) begin
                config1 <= shift;
            end
        end
    end

    // ------------------------------------------------------------
    // conversion sequencing
    // ------------------------------------------------------------
    logic [CW-1:0] conv_cnt;
    logic open_seen;
    logic supply_invalid_flag_seen;
    logic short_seen;
    wire pd = config1[PD_BIT];
    // shutdown only blocks the next start; the serial side never looks at it.
    wire conv_start = !converting && !pd && supply_ok;
    wire conv_done = converting && (conv_cnt == CONV_LAST);
    wire supply_invalid_flag_now = supply_invalid_flag_seen | !supply_ok;
    wire open_now = open_seen | trip;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            converting <= 1'b0;
            conv_cnt <= '0;
            open_seen <= 1'b0;
            supply_invalid_flag_seen <= 1'b0;
            short_seen <= 1'b0;
            power_down_select <= 1'b0;
        end else begin
            power_down_select <= pd;
            if (conv_start) begin
                converting <= 1'b1;
                conv_cnt <= '0;
                open_seen <= 1'b0;
                supply_invalid_flag_seen <= 1'b0;
                short_seen <= 1'b0;
            end else if (conv_done) begin
                converting <= 1'b0;
            end else if (converting) begin
                conv_cnt <= conv_cnt + 1'b1;
                open_seen <= open_now;
                supply_invalid_flag_seen <= supply_invalid_flag_now;
                short_seen <= short_seen | shorted;
            end
        end
    end

    // supply flag is set every cycle the supply is bad; a result update wins but carries the flag in
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            local_result <= '{hi: RESULT_RESET, lo: RESULT_RESET};
            remote_result <= '{hi: RESULT_RESET, lo: RESULT_RESET};
        end else if (conv_done) begin
            local_result.hi <= local_sample.whole;
            local_result.lo <= tmbs_low_byte(local_sample.frac, supply_invalid_flag_now, 1'b0);
            remote_result.hi <= (short_seen | shorted) ? SHORT_TEMP : remote_sample.whole;
            remote_result.lo <= tmbs_low_byte(remote_sample.frac, supply_invalid_flag_now, open_now);
        end else if (!supply_ok) begin
            local_result.lo[SUPPLY_INVALID_FLAG_BIT] <= 1'b1;
            remote_result.lo[SUPPLY_INVALID_FLAG_BIT] <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence seq_addr_byte;
        state == ST_ADDR && byte_done && !tmo_hit && !start_seen && !stop_seen;
    endsequence

    AST_OPEN_FLAG: assert property (conv_done && open_now |=> remote_result.lo[OPEN_BIT])
        else $error("open flag missing after comparator trip");
    AST_SHORT_VALUE: assert property (conv_done && shorted |=> remote_result.hi == 8'hc0)
        else $error("shorted input not reported as minus 64");
    AST_NO_START_BAD_SUPPLY: assert property (!converting && !supply_ok |=> !converting)
        else $error("conversion started without valid supply");
    AST_SUPPLY_INVALID_FLAG_FLAG: assert property (!supply_ok |=> local_result.lo[1] && remote_result.lo[1])
        else $error("supply invalid flag not set");
    AST_TIMEOUT_RELEASE: assert property (tmo_hit |=> sda_oe_n && state == ST_IGNORE)
        else $error("timeout did not release the bus");
    AST_PD_HOLDS: assert property (!converting && pd |=> !converting)
        else $error("conversion started in shutdown");
    AST_CONTINUOUS: assert property (conv_done && !pd && supply_ok ##1 !pd && supply_ok |=> converting)
        else $error("conversions not back to back");
    AST_ADDR_ACK: assert property (seq_addr_byte ##0 (addr_match && !hs_code) |=> !sda_oe_n [*2])
        else $error("matching address not acknowledged");
    AST_HS_NOACK: assert property (seq_addr_byte ##0 hs_code |=> sda_oe_n && hs_mode)
        else $error("high-speed code acknowledged or mode not entered");
    AST_PTR_STABLE: assert property (!ptr_load |=> $stable(pointer))
        else $error("pointer changed outside a write");
    AST_ACK_HELD: assert property (state == ST_WR_ACK && scl && !scl_fall |=> !sda_oe_n || start_seen || stop_seen
        || tmo_hit || $past(start_seen) || $past(stop_seen) || $past(tmo_hit))
        else $error("acknowledge released during clock high");

endmodule

// >>> hw/tmbs_sync.sv
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes inputs are asynchronous to clk; the output only follows
 * once the second and third stages agree.
 */
`timescale 1ns/1ns
module tmbs_sync #(
    parameter int WIDTH = 5,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] agree;

    assign agree = ~(stage2 ^ stage3);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1 <= RESET_VALUE;
            stage2 <= RESET_VALUE;
            stage3 <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            sync_out <= (agree & stage3) | (~agree & sync_out);
        end
    end

endmodule

// >>> tb/tb.sv
/*
 * Self-checking bench for the bus slave: bus transfers through the master
 * model, supply and sensor fault inputs driven on falling clk edges.
 * Assumes shortened timeout and conversion counts given to the dut.
 */
`timescale 1ns/1ns
module tb;
    import tmbs_pkg::*;
    localparam logic [6:0] ADDR = 7'h2a;
    // long enough that a zero pointer byte with both acks and the stop stays clear of it
    localparam int TO_CYC = 400;
    localparam int CV_CYC = 20;
    logic clk, reset_n, supply_valid, remote_comparator_trip, remote_short;
    logic sda_out, sda_oe_n, power_down_select, converting, hs_mode, m_scl, m_sda, ack;
    logic [7:0] d0, d1;
    tmbs_result_t local_result, remote_result;
    tmbs_sample_t local_sample, remote_sample;
    int num_errors = 0;
    int checked = 0;
    // open-drain wire with pull-up; the slave never drives SCL
    wire logic sda_bus = m_sda & (sda_oe_n | sda_out);

    tmbs_master m (.clk(clk), .sda_bus(sda_bus), .scl(m_scl), .sda(m_sda));

    tmbs_slave #(.TIMEOUT_CYC(TO_CYC), .CONV_CYC(CV_CYC)) dut (
        .clk(clk), .reset_n(reset_n), .scl_in(m_scl), .sda_in(sda_bus), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .slave_addr(ADDR), .supply_valid(supply_valid),
        .remote_comparator_trip(remote_comparator_trip), .remote_short(remote_short),
        .local_sample(local_sample), .remote_sample(remote_sample),
        .power_down_select(power_down_select), .converting(converting), .hs_mode(hs_mode),
        .local_result(local_result), .remote_result(remote_result)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0 ] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask

    task automatic write_reg(input logic [7:0] ptr, input logic [7:0] data, input logic with_data);
        m.start();
        m.send_byte({ADDR, 1'b0}, ack);
        check("address ack", 16'h1, 16'(ack));
        m.send_byte(ptr, ack);
        check("pointer ack", 16'h1, 16'(ack));
        if (with_data) begin
            m.send_byte(data, ack);
            check("data ack", 16'h1, 16'(ack));
        end
        m.stop();
    endtask

    task automatic read_two(output logic [7:0] a, output logic [7:0] b);
        m.start();
        m.send_byte({ADDR, 1'b1}, ack);
        check("read address ack", 16'h1, 16'(ack));
        m.recv_byte(1'b1, a);
        m.recv_byte(1'b0, b);
        m.stop();
    endtask

    task automatic wait_conv();
        for (int i = 0; i < 100 && converting !== 1'b1; i++) begin
            @(negedge clk);
        end
        check("conversion running", 16'h1, 16'(converting));
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        $display("[ERR] watchdog expected finish seen hang");
        report_and_stop();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        reset_n = 1'b0;
        supply_valid = 1'b0;
        remote_comparator_trip = 1'b0;
        remote_short = 1'b0;
        local_sample = '{whole: 8'h19, frac: 4'h4};
        remote_sample = '{whole: 8'he7, frac: 4'h8};
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        repeat (30) @(negedge clk);
        check("idle converting", 16'h0, 16'(converting));
        check("local invalid supply", 16'h0002, local_result);
        check("remote invalid supply", 16'h0002, remote_result);
        check("sda released", 16'h1, 16'(sda_oe_n));
        check("sda drive level", 16'h0, 16'(sda_out));
        $display("test supply finished");

        supply_valid = 1'b1;
        wait_conv();
        repeat (CV_CYC + 10) @(negedge clk);
        check("local result", 16'h1940, local_result);
        check("remote result", 16'he780, remote_result);
        remote_comparator_trip = 1'b1;
        repeat (2 * CV_CYC + 10) @(negedge clk);
        check("open flag", 16'h1, 16'(remote_result.lo[OPEN_BIT]));
        remote_comparator_trip = 1'b0;
        remote_short = 1'b1;
        repeat (2 * CV_CYC + 10) @(negedge clk);
        check("short value", 16'(SHORT_TEMP), 16'(remote_result.hi));
        remote_short = 1'b0;
        $display("test conversion finished");

        write_reg(PTR_CONFIG1, 8'h40, 1'b1);
        repeat (4) @(negedge clk);
        check("power down", 16'h1, 16'(power_down_select));
        repeat (CV_CYC + 10) @(negedge clk);
        check("stopped", 16'h0, 16'(converting));
        read_two(d0, d1);
        check("config first", 16'h0040, 16'(d0));
        check("config second", 16'h0040, 16'(d1));
        read_two(d0, d1);
        check("config again", 16'h0040, 16'(d0));
        write_reg(PTR_CONFIG1, 8'h00, 1'b1);
        wait_conv();
        $display("test shutdown finished");

        m.start();
        m.send_byte({ADDR ^ 7'h01, 1'b0}, ack);
        check("foreign address", 16'h0, 16'(ack));
        m.stop();
        m.start();
        m.send_byte(8'h0b, ack);
        check("master code ack", 16'h0, 16'(ack));
        check("hs entered", 16'h1, 16'(hs_mode));
        m.start();
        m.send_byte({ADDR, 1'b0}, ack);
        check("hs address ack", 16'h1, 16'(ack));
        m.send_byte(PTR_LOCAL_HI, ack);
        m.stop();
        repeat (10) @(negedge clk);
        check("hs left", 16'h0, 16'(hs_mode));
        read_two(d0, d1);
        check("local high", 16'h0019, 16'(d0));
        $display("test addressing finished");

        m.start();
        for (int i = 6; i >= 0; i--) begin
            m.bit_slot(ADDR[i], ack);
        end
        m.bit_slot(1'b0, ack);
        m.stall(TO_CYC + 20);
        check("timeout release", 16'h1, 16'(sda_oe_n));
        m.start();
        m.send_byte({ADDR, 1'b0}, ack);
        check("after timeout ack", 16'h1, 16'(ack));
        m.stop();
        $display("test timeout finished");
        report_and_stop();
    end
endmodule

// >>> tb/tmbs_master.sv
/*
 * Behavioural two-wire bus master that drives SCL and its share of SDA.
 * Assumes the bench resolves SDA from all drivers and feeds sda_bus back;
 * SCL stands high between frames and every move lands on a falling clk edge.
 */
`timescale 1ns/1ns
module tmbs_master (
    input wire logic clk,
    input wire logic sda_bus,
    output logic scl,
    output logic sda
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    // ------------------------------------------------------------
    // bit and frame primitives
    // ------------------------------------------------------------
    // 320 ns bit slot, well above the slave's sampling needs
    task automatic bit_slot(input logic b, output logic seen);
        scl = 1'b0;
        tick(2);
        sda = b;
        tick(6);
        scl = 1'b1;
        tick(4);
        seen = sda_bus;
        tick(4);
    endtask

    task automatic start();
        if (!sda) begin
            scl = 1'b0;
            tick(2);
            sda = 1'b1;
            tick(6);
            scl = 1'b1;
            tick(8);
        end
        sda = 1'b0;
        tick(8);
    endtask

    task automatic stop();
        scl = 1'b0;
        tick(2);
        sda = 1'b0;
        tick(6);
        scl = 1'b1;
        tick(8);
        sda = 1'b1;
        tick(8);
    endtask

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(d[i], s);
        end
        bit_slot(1'b1, s);
        ack = !s;
    endtask

    // a final byte is left unacknowledged to end a read
    task automatic recv_byte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(1'b1, d[i]);
        end
        bit_slot(!ack, s);
    endtask

    // holds SCL low to provoke the slave's timeout
    task automatic stall(input int n);
        scl = 1'b0;
        tick(n);
    endtask
endmodule
